// [core/ts_pseudowire_sublayer_framer.sv]
/*
  Receiver for the transport stream pseudowire sublayer: parses the
  single-channel and multi-channel headers, checks counters, routes
  each 188-byte packet to its channel, drops or substitutes nulls.
  Assumes a byte stream with start and end marks, no back-pressure,
  and mode and flow selection held steady during a frame.
*/
// Operation
// - single-channel header fields in fixed order
// - counter used only when flagged valid
// - code 01 latency probe, 10/11 undefined
// - reserved bits ignored on receive
// - counter steps by one per packet
// - one single-channel session per channel
// - accept one to seven packets per frame; no limit is enforced in single mode
// - null packets may be discarded
// - only one stream selector supported
// - multi-channel word adds count field
// - packet count legal from one to ten
// - four-byte word plus twenty-byte entry array
// - entries past the count are ignored
// - channel pointer routes each packet
// - per-channel order count tracked
// - channel packets replaceable by nulls
// - each segment is one 188-byte packet
// - malformed headers cause frame drop
`timescale 1ns/100ps
`default_nettype none
module ts_pseudowire_sublayer_framer (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_mode_multi,
  input wire logic [2:0] i_flow_sel,
  input wire logic i_null_drop_en,
  input wire logic i_subst_en,
  input wire logic [7:0] i_subst_chan,
  input wire logic [7:0] i_rx_byte,
  input wire logic i_rx_valid,
  input wire logic i_rx_sop,
  input wire logic i_rx_eop,
  output logic o_ts_valid,
  output ts_sublayer_pkg::ts_beat_type o_ts_beat,
  output logic o_hdr_drop,
  output logic o_probe_seen,
  output logic o_trunc_err,
  output logic o_seq_gap,
  output logic [15:0] o_last_counter,
  output logic o_chan_gap,
  output logic [7:0] o_gap_chan,
  output logic o_null_dropped
);
  import ts_sublayer_pkg::*;

  parse_state_type state_r;
  parse_state_type state_nxt;
  logic [7:0] cnt_r;
  logic [23:0] hdr_r;
  logic mode_multi_r;
  logic [3:0] ts_count_r;
  logic [3:0] pkt_idx_r;
  logic [7:0] ptr_r [ARRAY_ENTRIES];
  logic [3:0] ord_r [ARRAY_ENTRIES];
  logic [3:0] exp_tab_r [CHAN_TABLE];
  logic [CHAN_TABLE-1:0] seen_r;
  logic drain_r;
  logic drop_pkt_r;
  logic subst_pkt_r;
  sub_hdr_type hdr_word;
  logic hdr_done;
  logic hdr_bad;
  logic hdr_probe;
  logic hdr_short;
  logic payload_push;
  logic pkt_end;
  logic frame_over;
  logic chan_chk;
  logic [7:0] chan_cur;
  logic [3:0] ord_cur;
  logic seq_strobe;
  logic shift;
  ts_beat_type beat_in;
  ts_beat_type [DELAY_DEPTH-1:0] taps;
  ts_beat_type head;
  logic out_fire;
  logic null_now;
  logic subst_now;
  logic drop_now;
  logic subst_cur;

  // header word completes on its fourth byte, msb first
  assign hdr_word = {hdr_r, i_rx_byte};
  assign hdr_done = i_rx_valid && !i_rx_sop && !i_rx_eop && (state_r == PS_HDR) && (cnt_r == HDR_LAST_IDX);
  assign hdr_bad = hdr_fault(hdr_word, mode_multi_r, i_flow_sel);
  assign hdr_probe = (hdr_word.extended_type_code == EXT_PROBE);
  assign hdr_short = i_rx_valid && i_rx_eop && (i_rx_sop || (state_r == PS_HDR));
  assign seq_strobe = hdr_done && !hdr_bad && !hdr_probe && hdr_word.numbering_ok_flag;

  // payload bytes and packet boundaries, 188 bytes each
  assign payload_push = i_rx_valid && !i_rx_sop && (state_r == PS_PAYLOAD);
  assign pkt_end = payload_push && (cnt_r == TS_LAST_IDX);
  assign frame_over = pkt_end && mode_multi_r && (4'(pkt_idx_r + 4'h1) == ts_count_r);
  assign chan_cur = mode_multi_r ? ptr_r[pkt_idx_r] : CHAN_SINGLE;
  assign ord_cur = ord_r[pkt_idx_r];
  assign chan_chk = payload_push && mode_multi_r && (cnt_r == TS_FIRST_IDX);

  // parser next state; a start mark restarts the header unless it also carries the end mark
  always_comb begin
    state_nxt = state_r;
    if (i_rx_valid) begin
      if (i_rx_sop) begin
        state_nxt = i_rx_eop ? PS_IDLE : PS_HDR;
      end else begin
        case (state_r)
          PS_HDR: begin
            if (i_rx_eop) begin
              state_nxt = PS_IDLE;
            end else if (cnt_r == HDR_LAST_IDX) begin
              if (hdr_bad || hdr_probe) begin
                state_nxt = PS_DISCARD;
              end else if (mode_multi_r) begin
                state_nxt = PS_ARRAY;
              end else begin
                state_nxt = PS_PAYLOAD;
              end
            end
          end
          PS_ARRAY: begin
            if (i_rx_eop) begin
              state_nxt = PS_IDLE;
            end else if (cnt_r == ARRAY_LAST_IDX) begin
              state_nxt = PS_PAYLOAD;
            end
          end
          PS_PAYLOAD: begin
            if (i_rx_eop) begin
              state_nxt = PS_IDLE;
            end else if (frame_over) begin
              state_nxt = PS_DISCARD;
            end
          end
          PS_DISCARD: begin
            if (i_rx_eop) begin
              state_nxt = PS_IDLE;
            end
          end
          default: begin
            state_nxt = PS_IDLE;
          end
        endcase
      end
    end
  end

  // one session, one parser: a single flow is tracked at a time
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      state_r <= PS_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // byte position within header, entry array or transport packet
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      cnt_r <= 8'h00;
    end else if (i_rx_valid) begin
      if (i_rx_sop) begin
        cnt_r <= 8'h01;
      end else if (state_r == PS_HDR) begin
        cnt_r <= (cnt_r == HDR_LAST_IDX) ? TS_FIRST_IDX : 8'(cnt_r + 8'h01);
      end else if (state_r == PS_ARRAY) begin
        cnt_r <= (cnt_r == ARRAY_LAST_IDX) ? TS_FIRST_IDX : 8'(cnt_r + 8'h01);
      end else if (state_r == PS_PAYLOAD) begin
        cnt_r <= (cnt_r == TS_LAST_IDX) ? TS_FIRST_IDX : 8'(cnt_r + 8'h01);
      end
    end
  end

  // header capture; mode comes from the control side, not the header
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      hdr_r <= 24'h000000;
      mode_multi_r <= 1'b0;
      ts_count_r <= 4'h0;
    end else if (i_rx_valid) begin
      if (i_rx_sop || (state_r == PS_HDR)) begin
        hdr_r <= {hdr_r[15:0], i_rx_byte};
      end
      if (i_rx_sop) begin
        mode_multi_r <= i_mode_multi;
      end
      if (hdr_done) begin
        ts_count_r <= ts_count_of(hdr_word);
      end
    end
  end

  // entry array: pointer byte, then order count in the high nibble
  always_ff @(posedge i_clk) begin
    if (i_rx_valid && !i_rx_sop && (state_r == PS_ARRAY)) begin
      if (!cnt_r[0]) begin
        ptr_r[cnt_r[4:1]] <= i_rx_byte;
      end else begin
        ord_r[cnt_r[4:1]] <= i_rx_byte[ORD_MSB:ORD_LSB];
      end
    end
  end

  // packet index; single-channel frames carry any number of packets
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      pkt_idx_r <= 4'h0;
    end else if (hdr_done) begin
      pkt_idx_r <= 4'h0;
    end else if (pkt_end && mode_multi_r) begin
      pkt_idx_r <= 4'(pkt_idx_r + 4'h1);
    end
  end

  // per-channel accounting; the seen bits guard the unreset table
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      seen_r <= '0;
      o_chan_gap <= 1'b0;
      o_gap_chan <= 8'h00;
    end else begin
      o_chan_gap <= chan_chk && seen_r[chan_cur] && (exp_tab_r[chan_cur] != ord_cur);
      if (chan_chk) begin
        seen_r[chan_cur] <= 1'b1;
        o_gap_chan <= chan_cur;
        exp_tab_r[chan_cur] <= 4'(ord_cur + 4'h1);
      end
    end
  end

  // header and framing events, one-cycle pulses
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_hdr_drop <= 1'b0;
      o_probe_seen <= 1'b0;
      o_trunc_err <= 1'b0;
    end else begin
      o_hdr_drop <= (hdr_done && hdr_bad) || hdr_short;
      o_probe_seen <= hdr_done && !hdr_bad && hdr_probe;
      o_trunc_err <= i_rx_valid && (((state_r == PS_ARRAY) && (i_rx_eop || i_rx_sop)) || (!i_rx_sop
        && (state_r == PS_PAYLOAD) && i_rx_eop && ((cnt_r != TS_LAST_IDX) || (mode_multi_r && !frame_over))));
    end
  end

  ts_counter_check u_counter_check (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_strobe(seq_strobe),
    .i_value(hdr_word.packet_counter_field),
    .o_gap(o_seq_gap),
    .o_last(o_last_counter)
  );

  // drain the look-ahead after a frame end; the end mark wins, as the last byte is also a push
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      drain_r <= 1'b0;
    end else if (i_rx_valid && i_rx_eop) begin
      drain_r <= 1'b1;
    end else if (payload_push) begin
      drain_r <= 1'b0;
    end
  end

  assign shift = payload_push || drain_r;
  assign beat_in = '{v: payload_push, data: i_rx_byte, first: (cnt_r == TS_FIRST_IDX),
    last: (cnt_r == TS_LAST_IDX), idx: cnt_r, chan: chan_cur};

  ts_beat_delay u_beat_delay (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_shift(shift),
    .i_beat(beat_in),
    .o_taps(taps)
  );

  // null detection looks two bytes ahead at the packet identifier
  assign head = taps[TAP_HEAD];
  assign out_fire = shift && head.v;
  assign null_now = head.first && taps[TAP_PID_HI].v && (taps[TAP_PID_HI].data[4:0] == NULL_PID_HI)
    && (taps[TAP_PID_LO].data == NULL_PID_LO);
  assign subst_now = i_subst_en && (head.chan == i_subst_chan);
  assign subst_cur = head.first ? subst_now : subst_pkt_r;
  assign drop_now = head.first ? (null_now && i_null_drop_en && !subst_now) : drop_pkt_r;

  // decisions are latched at the first byte so a packet is never split
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      drop_pkt_r <= 1'b0;
      subst_pkt_r <= 1'b0;
    end else if (out_fire && head.first) begin
      drop_pkt_r <= null_now && i_null_drop_en && !subst_now;
      subst_pkt_r <= subst_now;
    end
  end

  // output stage; substituted packets keep the channel's byte rate
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_ts_valid <= 1'b0;
      o_ts_beat <= '0;
      o_null_dropped <= 1'b0;
    end else begin
      o_ts_valid <= out_fire && !drop_now;
      o_null_dropped <= out_fire && head.first && drop_now;
      if (out_fire) begin
        o_ts_beat <= head;
        o_ts_beat.data <= subst_cur ? null_byte(head.idx) : head.data;
      end
    end
  end

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_sys_rst);

  sequence s_hdr_end;
    hdr_done;
  endsequence
  sequence s_hdr_good_multi;
    s_hdr_end ##0 (!hdr_bad && !hdr_probe && mode_multi_r);
  endsequence

  chk_check_bit_drop: assert property (s_hdr_end ##0 hdr_word.pw_check_bit |=> o_hdr_drop)
    else $error("set check bit not dropped");
  chk_counter_gate: assert property (s_hdr_end ##0 !hdr_word.numbering_ok_flag
    |=> !o_seq_gap && $stable(o_last_counter))
    else $error("counter used without valid flag");
  chk_probe_pulse: assert property (s_hdr_end ##0 (hdr_word.extended_type_code == EXT_PROBE
    && !hdr_bad) |=> o_probe_seen && !o_hdr_drop ##0 (state_r == PS_DISCARD))
    else $error("probe header not reported");
  chk_undef_drop: assert property (s_hdr_end ##0 hdr_word.extended_type_code[EXT_UNDEF_BIT]
    |=> o_hdr_drop && (state_r == PS_DISCARD))
    else $error("undefined code not dropped");
  chk_flow_filter: assert property (s_hdr_end ##0 (hdr_word.stream_selector != i_flow_sel)
    |=> o_hdr_drop)
    else $error("foreign stream accepted");
  chk_count_range: assert property (s_hdr_end ##0 (mode_multi_r && !hdr_probe
    && (ts_count_of(hdr_word) > TS_COUNT_MAX)) |=> o_hdr_drop)
    else $error("bad packet count accepted");
  chk_array_entry: assert property (s_hdr_good_multi |=> (state_r == PS_ARRAY)
    && (cnt_r == TS_FIRST_IDX) && (pkt_idx_r == 4'h0))
    else $error("entry array not entered");
  chk_chan_gap: assert property (chan_chk && seen_r[chan_cur] && (exp_tab_r[chan_cur] != ord_cur)
    |=> o_chan_gap && (o_gap_chan == $past(chan_cur)))
    else $error("channel order gap missed");
  chk_null_drop: assert property (out_fire && null_now && i_null_drop_en && !subst_now
    |=> !o_ts_valid && o_null_dropped)
    else $error("null packet forwarded");
  chk_subst_sync: assert property (out_fire && head.first && subst_now && !drop_now
    |=> o_ts_valid && (o_ts_beat.data == TS_SYNC))
    else $error("substitute packet lacks sync byte");

endmodule
`default_nettype wire

// [core/ts_sublayer_pkg.sv]
/*
  Shared types and constants for the pseudowire sublayer receiver.
  Assumes one byte per beat, header bytes arriving most significant first.
*/
package ts_sublayer_pkg;

  // first header word as it sits on the wire, msb first
  typedef struct packed {
    logic pw_check_bit;
    logic numbering_ok_flag;
    logic [1:0] extended_type_code;
    logic reserved_pad_bit;
    logic [2:0] stream_selector;
    logic [7:0] mid_field;
    logic [15:0] packet_counter_field;
  } sub_hdr_type;

  // one payload byte travelling to the stream processing side
  typedef struct packed {
    logic v;
    logic [7:0] data;
    logic first;
    logic last;
    logic [7:0] idx;
    logic [7:0] chan;
  } ts_beat_type;

  typedef enum logic [2:0] {PS_IDLE, PS_HDR, PS_ARRAY, PS_PAYLOAD, PS_DISCARD} parse_state_type;

  localparam logic [7:0] HDR_LAST_IDX = 8'h03;
  localparam logic [7:0] ARRAY_LAST_IDX = 8'h13;
  localparam logic [7:0] TS_FIRST_IDX = 8'h00;
  localparam logic [7:0] TS_LAST_IDX = 8'hBB;
  localparam int ARRAY_ENTRIES = 10;
  localparam int CHAN_TABLE = 256;
  localparam logic [3:0] TS_COUNT_MIN = 4'h1;
  localparam logic [3:0] TS_COUNT_MAX = 4'hA;
  localparam int TS_COUNT_MSB = 3;
  localparam int ORD_MSB = 7;
  localparam int ORD_LSB = 4;
  localparam logic [1:0] EXT_DATA = 2'h0;
  localparam logic [1:0] EXT_PROBE = 2'h1;
  localparam int EXT_UNDEF_BIT = 1;
  localparam logic [7:0] CHAN_SINGLE = 8'h00;
  localparam logic [7:0] TS_SYNC = 8'h47;
  localparam logic [4:0] NULL_PID_HI = 5'h1F;
  localparam logic [7:0] NULL_HDR_B1 = 8'h1F;
  localparam logic [7:0] NULL_PID_LO = 8'hFF;
  localparam logic [7:0] NULL_HDR_B3 = 8'h10;
  localparam logic [7:0] NULL_FILL = 8'hFF;
  localparam logic [7:0] NULL_IDX_B1 = 8'h01;
  localparam logic [7:0] NULL_IDX_B2 = 8'h02;
  localparam logic [7:0] NULL_IDX_B3 = 8'h03;
  localparam int DELAY_DEPTH = 3;
  localparam int TAP_PID_LO = 0;
  localparam int TAP_PID_HI = 1;
  localparam int TAP_HEAD = 2;

  function automatic logic [3:0] ts_count_of(input sub_hdr_type h);
    return h.mid_field[TS_COUNT_MSB:0];
  endfunction

  // reserved pad bit and reserved fields are never looked at
  function automatic logic hdr_fault(input sub_hdr_type h, input logic multi, input logic [2:0] flow);
    logic cnt_bad;
    cnt_bad = (ts_count_of(h) < TS_COUNT_MIN) || (ts_count_of(h) > TS_COUNT_MAX);
    return h.pw_check_bit || h.extended_type_code[EXT_UNDEF_BIT] || (h.stream_selector != flow)
      || (multi && (h.extended_type_code == EXT_DATA) && cnt_bad);
  endfunction

  // byte of a null transport packet at a given position
  function automatic logic [7:0] null_byte(input logic [7:0] idx);
    if (idx == TS_FIRST_IDX) return TS_SYNC;
    else if (idx == NULL_IDX_B1) return NULL_HDR_B1;
    else if (idx == NULL_IDX_B2) return NULL_PID_LO;
    else if (idx == NULL_IDX_B3) return NULL_HDR_B3;
    else return NULL_FILL;
  endfunction

endpackage

// [core/ts_beat_delay.sv]
/*
  Short delay line for payload beats, giving a look-ahead on the
  packet identifier. Assumes the caller shifts it on every push and
  keeps shifting while draining after a frame end.
*/
`timescale 1ns/100ps
`default_nettype none
module ts_beat_delay (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_shift,
  input wire ts_sublayer_pkg::ts_beat_type i_beat,
  output ts_sublayer_pkg::ts_beat_type [ts_sublayer_pkg::DELAY_DEPTH-1:0] o_taps
);
  import ts_sublayer_pkg::*;

  // shift only on demand so gaps inside a payload stall the line
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_taps <= '0;
    end else if (i_shift) begin
      o_taps <= {o_taps[DELAY_DEPTH-2:0], i_beat};
    end
  end

endmodule
`default_nettype wire

// [core/ts_counter_check.sv]
/*
  Packet counter continuity check for the sublayer header.
  Assumes a one-cycle strobe only for headers whose counter is valid.
*/
`timescale 1ns/100ps
`default_nettype none
module ts_counter_check (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_strobe,
  input wire logic [15:0] i_value,
  output logic o_gap,
  output logic [15:0] o_last
);
  import ts_sublayer_pkg::*;

  logic seen_r;

  // the first counter is never judged, its start value is arbitrary
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      seen_r <= 1'b0;
      o_last <= 16'h0000;
      o_gap <= 1'b0;
    end else begin
      o_gap <= i_strobe && seen_r && (i_value != 16'(o_last + 16'h0001));
      if (i_strobe) begin
        seen_r <= 1'b1;
        o_last <= i_value;
      end
    end
  end

  chk_counter_gap: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    i_strobe && seen_r && (i_value == 16'(o_last + 16'h0001)) |=> !o_gap)
    else $error("gap reported on consecutive counter");

endmodule
`default_nettype wire

// [tb/headend_tx_model.sv]
/* Headend-side frame source: builds the sublayer word, entry array and
   payload, then streams them off the falling edge, one byte per cycle with random idle cycles.
   Assumes the bench fills pay and ent before each call of send. */
`timescale 1ns/100ps
`default_nettype none
module headend_tx_model (
  input wire logic i_clk,
  output logic [7:0] o_byte,
  output logic o_valid,
  output logic o_sop,
  output logic o_eop
);
  logic [7:0] pay[$];
  logic [15:0] ent[$];
  logic [15:0] ctr = 16'h0000;
  initial begin
    o_byte = 8'h00;
    o_valid = 1'b0;
    o_sop = 1'b0;
    o_eop = 1'b0;
  end
  // the data line is not held, so show a changing value between bytes
  task automatic idle();
    o_valid <= 1'b0;
    o_sop <= 1'b0;
    o_eop <= 1'b0;
    o_byte <= ~o_byte;
  endtask
  // start value unpredictable to outside observers
  task automatic init();
    ctr = 16'($urandom());
  endtask
  // skip lets the bench lose frames on purpose
  task automatic send(input logic multi, input logic chk, input logic sok, input logic [1:0] ext,
                      input logic [2:0] flow, input logic [3:0] cnt, input logic [15:0] skip);
    logic [7:0] q[$];
    logic [31:0] w;
    ctr = ctr + skip + 16'h0001;
    w = {chk, sok, ext, 1'b0, flow, multi ? {4'h0, cnt} : 8'h00, ctr};
    for (int i = 3; i >= 0; i--) q.push_back(w[i*8 +: 8]);
    // unused entries go out as zero
    for (int i = 0; i < 10 && multi; i++) begin
      q.push_back(i < ent.size() ? ent[i][15:8] : 8'h00);
      q.push_back(i < ent.size() ? ent[i][7:0] : 8'h00);
    end
    foreach (pay[i]) q.push_back(pay[i]);
    foreach (q[i]) begin
      @(negedge i_clk);
      if ($urandom_range(15) == 0) begin
        idle();
        @(negedge i_clk);
      end
      o_byte <= q[i];
      o_valid <= 1'b1;
      o_sop <= (i == 0);
      o_eop <= (i == q.size() - 1);
    end
    @(negedge i_clk);
    idle();
    pay.delete();
    ent.delete();
  endtask
endmodule
`default_nettype wire

// [tb/tb.sv]
/* Self-checking bench for the sublayer receiver: random frames in both
   modes, malformed headers, counter jumps, null drop and substitution.
   Assumes the frame source model and the design package are compiled. */
`timescale 1ns/100ps
`default_nettype none
module tb;
  import ts_sublayer_pkg::*;
  logic i_clk = 1'b0;
  logic i_sys_rst = 1'b1;
  logic mm = 1'b0;
  logic nd = 1'b0;
  logic se = 1'b0;
  logic [7:0] sc = 8'h00;
  logic [2:0] flow = 3'h0;
  logic [7:0] rb;
  logic rv, rs, re, ts_valid, hdr_drop, probe, trunc, seq_gap, chan_gap, null_drop;
  ts_beat_type beat;
  logic [5:0] evv;
  assign evv = {hdr_drop, probe, trunc, seq_gap, chan_gap, null_drop};
  logic [15:0] last_ctr, last_ok;
  logic [7:0] gap_chan, lch;
  logic have_ok = 1'b0;
  logic [3:0] last_ord[256];
  logic seen_ch[256];
  logic [25:0] got[$], exp[$];
  int ev[6], ee[6];
  int num_errors = 0;
  int total_checks = 0;
  int n;
  always #50 i_clk = ~i_clk;
  headend_tx_model src (.i_clk(i_clk), .o_byte(rb), .o_valid(rv), .o_sop(rs), .o_eop(re));
  ts_pseudowire_sublayer_framer dut (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_mode_multi(mm),
    .i_flow_sel(flow), .i_null_drop_en(nd), .i_subst_en(se), .i_subst_chan(sc), .i_rx_byte(rb),
    .i_rx_valid(rv), .i_rx_sop(rs), .i_rx_eop(re), .o_ts_valid(ts_valid), .o_ts_beat(beat),
    .o_hdr_drop(hdr_drop), .o_probe_seen(probe), .o_trunc_err(trunc), .o_seq_gap(seq_gap),
    .o_last_counter(last_ctr), .o_chan_gap(chan_gap), .o_gap_chan(gap_chan), .o_null_dropped(null_drop));
  // collect beats and count pulses; pre-edge values are the settled ones
  always @(posedge i_clk) begin
    if (ts_valid === 1'b1) got.push_back({beat.data, beat.first, beat.last, beat.idx, beat.chan});
    foreach (ev[k]) if (evv[5-k] === 1'b1) ev[k]++;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    total_checks++;
    if (seen !== want) begin
      num_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask
  task automatic test_done();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  function automatic logic [7:0] nb(input int i);
    return i == 0 ? 8'h47 : i == 1 ? 8'h1F : i == 3 ? 8'h10 : 8'hFF;
  endfunction
  function automatic logic [3:0] nord(input logic [7:0] c);
    return seen_ch[c] ? last_ord[c] + 4'h1 : 4'($urandom());
  endfunction
  // one 188-byte packet; keep is low when the whole frame will be dropped
  task automatic pkt(input logic [7:0] ch, input logic [3:0] ord, input logic isnull, input logic keep);
    logic [7:0] b;
    logic sub;
    sub = se && ch == sc;
    if (mm) src.ent.push_back({ch, ord, 4'h0});
    if (keep && mm && seen_ch[ch] && ord != last_ord[ch] + 4'h1) ee[4]++;
    if (keep && mm) begin
      seen_ch[ch] = 1'b1;
      last_ord[ch] = ord;
      lch = ch;
    end
    if (keep && isnull && nd && !sub) ee[5]++;
    for (int i = 0; i < 188; i++) begin
      b = isnull ? nb(i) : i == 0 ? 8'h47 : 8'($urandom());
      // keep random packets clear of the null identifier
      if (i == 1 && !isnull) b = b & 8'hEF;
      src.pay.push_back(b);
      if (keep && (sub || !(isnull && nd))) exp.push_back({sub ? nb(i) : b, i == 0, i == 187, 8'(i), mm ? ch : CHAN_SINGLE});
    end
  endtask
  task automatic frame(input logic chk, input logic sok, input logic [1:0] ext, input logic [2:0] fl,
                       input logic [3:0] cnt, input logic [15:0] skip, input logic cmp);
    logic ok;
    ok = !chk && ext == 2'b00 && fl == flow && (!mm || (cnt >= 4'h1 && cnt <= 4'hA));
    ee[0] = !ok && ext != 2'b01;
    ee[1] = ext == 2'b01;
    ee[2] = mm && ok && int'(cnt) > src.ent.size();
    src.send(mm, chk, sok, ext, fl, cnt, skip);
    ee[3] = ok && sok && have_ok && src.ctr != last_ok + 16'h0001;
    if (ok && sok) begin
      last_ok = src.ctr;
      have_ok = 1'b1;
    end
    repeat (8) @(negedge i_clk);
    if (cmp) check(got.size(), exp.size());
    foreach (exp[i]) if (cmp && i < got.size()) check(got[i], exp[i]);
    foreach (ev[k]) check(ev[k], ee[k]);
    if (have_ok) check(last_ctr, last_ok);
    if (mm && ok) check(gap_chan, lch);
    got.delete();
    exp.delete();
    foreach (ev[k]) ev[k] = 0;
    foreach (ee[k]) ee[k] = 0;
  endtask
  // hang guard
  initial begin
    repeat (60000) @(posedge i_clk);
    num_errors++;
    test_done();
  end
  initial begin
    void'($urandom(17738));
    flow = 3'($urandom_range(7));
    foreach (seen_ch[c]) seen_ch[c] = 1'b0;
    repeat (10) @(negedge i_clk);
    i_sys_rst = 1'b0;
    src.init();
    // single mode, one to seven packets, five lost frames, nulls alternately kept and dropped
    for (int f = 0; f < 4; f++) begin
      n = f == 0 ? 7 : $urandom_range(1, 7);
      nd = f[0];
      for (int p = 0; p < n; p++) pkt(8'h00, 4'h0, p == 1, 1'b1);
      frame(1'b0, 1'b1, 2'b00, flow, 4'h0, f == 2 ? 16'h0005 : 16'h0000, 1'b1);
    end
    // counter flagged invalid: jump must pass unnoticed
    pkt(8'h00, 4'h0, 1'b0, 1'b1);
    frame(1'b0, 1'b0, 2'b00, flow, 4'h0, 16'h0100, 1'b1);
    // check bit, probe, undefined codes, foreign stream
    for (int c = 0; c < 5; c++) begin
      pkt(8'h00, 4'h0, 1'b0, 1'b0);
      frame(c == 0, 1'b1, c > 0 && c < 4 ? 2'(c) : 2'b00, c == 4 ? flow + 3'h1 : flow, 4'h0, 16'h0000, 1'b1);
    end
    // multi mode, ten-entry boundary first, one order jump
    mm = 1'b1;
    for (int f = 0; f < 4; f++) begin
      n = f == 0 ? 10 : $urandom_range(1, 10);
      for (int p = 0; p < n; p++) pkt(8'(p + 1), nord(8'(p + 1)) + (f == 2 && p == 0 ? 4'h2 : 4'h0), 1'b0, 1'b1);
      frame(1'b0, 1'b1, 2'b00, flow, 4'(n), 16'h0000, 1'b1);
    end
    // channel 9 substituted while null drop is on; a null on another channel is dropped
    se = 1'b1;
    sc = 8'h09;
    nd = 1'b1;
    pkt(8'h09, nord(8'h09), 1'b0, 1'b1);
    pkt(8'h03, nord(8'h03), 1'b1, 1'b1);
    pkt(8'h04, nord(8'h04), 1'b0, 1'b1);
    frame(1'b0, 1'b1, 2'b00, flow, 4'h3, 16'h0000, 1'b1);
    se = 1'b0;
    // reserved counts 0 and 11
    for (int c = 0; c < 2; c++) begin
      pkt(8'h01, 4'h0, 1'b0, 1'b0);
      frame(1'b0, 1'b1, 2'b00, flow, c == 0 ? 4'h0 : 4'hB, 16'h0000, 1'b1);
    end
    // fewer packets than the count promises
    pkt(8'h01, nord(8'h01), 1'b0, 1'b1);
    frame(1'b0, 1'b1, 2'b00, flow, 4'h2, 16'h0000, 1'b0);
    test_done();
  end
endmodule
`default_nettype wire
